// >>> hdl/ahbp_port.sv
// Host byte port of a four-channel 12-bit converter
module ahbp_port
    import ahbp_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             cs_b_in,
    input  wire logic             rd_b_in,
    input  wire logic             wr_b_in,
    input  wire logic             byte_select_high_in,
    input  wire logic             special_reg_select_in,
    input  wire logic [CH_W-1:0]  channel_addr_in,
    input  wire logic [7:0]       host_data_bus_in,
    output logic      [7:0]       host_data_bus_out,
    output logic                  host_data_bus_oe_b_out,
    output logic                  busy_b_out,
    // Core side
    input  wire logic             cal_active_in,
    input  wire logic             conv_done_in,
    input  wire logic [RES_W-1:0] conv_result_in,
    output logic                  conv_start_out,
    output logic      [CH_W-1:0]  conv_channel_out,
    output logic      [7:0]       special_reg_out
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [1:0] addr1_r;
    logic [1:0] addr2_r;
    logic [7:0] din1_r;
    logic [7:0] din2_r;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_r <= 6'h07;
            sync2_r <= 6'h07;
            addr1_r <= 2'h0;
            addr2_r <= 2'h0;
            din1_r  <= 8'h00;
            din2_r  <= 8'h00;
        end else begin
            sync1_r <= {special_reg_select_in, byte_select_high_in, 1'b0,
                        wr_b_in, rd_b_in, cs_b_in};
            sync2_r <= sync1_r;
            addr1_r <= channel_addr_in;
            addr2_r <= addr1_r;
            din1_r  <= host_data_bus_in;
            din2_r  <= din1_r;
        end
    end

    logic cs_b_s;
    logic rd_b_s;
    logic wr_b_s;
    logic byte_high_s;
    logic special_sel_s;
    assign cs_b_s        = sync2_r[0];
    assign rd_b_s        = sync2_r[1];
    assign wr_b_s        = sync2_r[2];
    assign byte_high_s   = sync2_r[4];
    assign special_sel_s = sync2_r[5];

    // Write is active only under chip select
    logic            wr_act;
    logic            wr_act_r;
    logic            wr_rise;
    logic [CH_W-1:0] addr_hold_r;
    logic [7:0]      din_hold_r;
    logic            special_hold_r;
    logic            wr_conv;
    logic            wr_special;
    assign wr_act     = !cs_b_s && !wr_b_s;
    assign wr_rise    = wr_act_r && !wr_act;
    assign wr_conv    = wr_rise && !special_hold_r;
    assign wr_special = wr_rise && special_hold_r;

    // Address, data and select as seen in the last strobe-low sample, so a host
    // that changes them together with the strobe rise is still taken correctly
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_act_r       <= 1'b0;
            addr_hold_r    <= CHAN_RST;
            din_hold_r     <= SPECIAL_RST;
            special_hold_r <= 1'b0;
        end else begin
            wr_act_r       <= wr_act;
            addr_hold_r    <= addr2_r;
            din_hold_r     <= din2_r;
            special_hold_r <= special_sel_s;
        end
    end

    // ----------------------------------------
    // Conversion control
    // ----------------------------------------
    ahbp_state_t      state_r;
    logic [RES_W-1:0] result_r;
    logic [7:0]       special_r;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= AHBP_IDLE;
        end else if (cal_active_in) begin
            state_r <= AHBP_CAL;
        end else begin
            unique case (state_r)
                AHBP_IDLE: begin
                    if (wr_conv) begin
                        state_r <= AHBP_CONV;
                    end
                end
                AHBP_CONV: begin
                    if (conv_done_in) begin
                        state_r <= AHBP_IDLE;
                    end
                end
                AHBP_CAL: begin
                    // Calibration ends with a normal conversion
                    state_r <= AHBP_CONV;
                end
                default: state_r <= AHBP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            conv_start_out <= 1'b0;
        end else begin
            // Only an idle converter takes a start; busy or calibrating refuses it
            conv_start_out <= wr_conv && !cal_active_in
                              && state_r == AHBP_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            conv_channel_out <= CHAN_RST;
        end else if (wr_conv) begin
            conv_channel_out <= addr_hold_r;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            result_r <= RESULT_RST;
        end else if (conv_done_in) begin
            result_r <= conv_result_in;
        end
    end

    // Special register writes share the strobe with the select high
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            special_r <= SPECIAL_RST;
        end else if (wr_special) begin
            special_r <= din_hold_r;
        end
    end
    assign special_reg_out = special_r;

    logic busy_now;
    assign busy_now = state_r != AHBP_IDLE || cal_active_in;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_b_out <= 1'b1;
        end else begin
            busy_b_out <= !busy_now;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            host_data_bus_out      <= 8'h00;
            host_data_bus_oe_b_out <= 1'b1;
        end else begin
            host_data_bus_oe_b_out <= !(!cs_b_s && !rd_b_s);
            if (special_sel_s) begin
                host_data_bus_out <= special_r;
            end else if (byte_high_s) begin
                host_data_bus_out <= {busy_now, 3'h0, result_r[11:8]};
            end else begin
                host_data_bus_out <= result_r[7:0];
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence wr_cmd_s;
        wr_conv && !cal_active_in && state_r == AHBP_IDLE;
    endsequence

    sequence wr_refused_s;
        wr_conv && state_r != AHBP_IDLE;
    endsequence

    chk_start_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wr_cmd_s |=> conv_start_out && state_r == AHBP_CONV)
        else $error("conversion not started on write");
    chk_cal_ignore: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        cal_active_in |=> !conv_start_out)
        else $error("start during calibration");
    chk_chan_latch: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wr_conv |=> conv_channel_out == $past(addr_hold_r))
        else $error("channel not latched");
    chk_start_refused: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wr_refused_s |=> !conv_start_out)
        else $error("start taken while not idle");
    chk_busy_level: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        busy_now |=> !busy_b_out)
        else $error("busy not low");
    chk_oe_gate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (cs_b_s || rd_b_s) |=> host_data_bus_oe_b_out)
        else $error("bus driven without read");
    chk_low_byte: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!special_sel_s && !byte_high_s) |=> host_data_bus_out == $past(result_r[7:0]))
        else $error("low byte wrong");
    chk_high_byte: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!special_sel_s && byte_high_s) |=> host_data_bus_out[3:0] == $past(result_r[11:8]))
        else $error("high byte wrong");
    chk_high_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!special_sel_s && byte_high_s) |=> host_data_bus_out[6:4] == 3'h0)
        else $error("high byte pad not zero");
    chk_status_bit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!special_sel_s && byte_high_s) |=> host_data_bus_out[7] == !busy_b_out)
        else $error("status bit not inverse busy");
    chk_special_rd: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        special_sel_s |=> host_data_bus_out == $past(special_r))
        else $error("special register not on bus");

endmodule

// >>> common/ahbp_pkg.sv
// Constants and types for the converter host byte port
package ahbp_pkg;

    // ----------------------------------------
    // Widths and timing
    // ----------------------------------------
    localparam int unsigned RES_W         = 12;
    localparam int unsigned CH_W          = 2;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned WR_MIN_NS     = 100;
    localparam int unsigned WR_MIN_CYC    = (WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
    localparam logic [CH_W-1:0]  CHAN_RST   = 2'h0;
    localparam logic [7:0]       SPECIAL_RST = 8'h00;

    typedef enum logic [2:0] {
        AHBP_IDLE = 3'b001,
        AHBP_CONV = 3'b010,
        AHBP_CAL  = 3'b100
    } ahbp_state_t;

endpackage

// >>> sim/ahbp_host.sv
// Host processor model for the converter byte port
module ahbp_host
    import ahbp_pkg::*;
(
    input  wire logic            clk_in,
    input  wire logic [7:0]      dev_data_in,
    input  wire logic            dev_oe_b_in,
    output logic                 cs_b_out,
    output logic                 rd_b_out,
    output logic                 wr_b_out,
    output logic                 byte_high_out,
    output logic                 special_sel_out,
    output logic      [CH_W-1:0] addr_out,
    output logic      [7:0]      bus_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] drv = 8'hA5;
    initial {cs_b_out, rd_b_out, wr_b_out, byte_high_out, special_sel_out, addr_out} = 7'h70;
    // Wire level; released bus toggles so stale data never reads as valid
    assign bus_out = dev_oe_b_in ? drv : dev_data_in;

    task automatic wr(input logic [CH_W-1:0] ch, input logic sel, input logic [7:0] d,
                      input logic cs);
        @(posedge clk_in);
        #1;
        cs_b_out        = ~cs;
        wr_b_out        = 1'b0;
        addr_out        = ch;
        special_sel_out = sel;
        drv             = d;
        repeat (WR_MIN_CYC) @(posedge clk_in);
        #1;
        wr_b_out = 1'b1;
        cs_b_out = 1'b1;
        drv      = ~d;
    endtask

    task automatic rd(input logic hb, output logic [7:0] q, output logic oe_b);
        @(posedge clk_in);
        #1;
        cs_b_out        = 1'b0;
        rd_b_out        = 1'b0;
        byte_high_out   = hb;
        special_sel_out = 1'b0;
        // Registered bus answers three edges later; look between edges, not on one
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        q    = bus_out;
        oe_b = dev_oe_b_in;
        @(posedge clk_in);
        #1;
        rd_b_out = 1'b1;
        cs_b_out = 1'b1;
        drv      = ~drv;
    endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the converter host byte port
module testbench
    import ahbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_b = 0, cal = 0, done = 0, busy_b, oe_b, start, cs_b, rd_b, wr_b;
    logic byte_high, special_sel;
    logic [11:0] res = 12'h000;
    logic [7:0]  bus, dout, sreg, q, d;
    logic [1:0]  addr, chan;
    logic        ob, got;
    integer      seed = 32'he191, errors = 0, num_checks = 0;
    initial forever #4 clk = ~clk;

    ahbp_host h (.clk_in(clk), .dev_data_in(dout), .dev_oe_b_in(oe_b), .cs_b_out(cs_b),
        .rd_b_out(rd_b), .wr_b_out(wr_b), .byte_high_out(byte_high),
        .special_sel_out(special_sel), .addr_out(addr),
        .bus_out(bus));
    ahbp_port uut (.clk_in(clk), .rst_b_in(rst_b), .cs_b_in(cs_b), .rd_b_in(rd_b),
        .wr_b_in(wr_b), .byte_select_high_in(byte_high), .special_reg_select_in(special_sel),
        .channel_addr_in(addr), .host_data_bus_in(bus), .host_data_bus_out(dout),
        .host_data_bus_oe_b_out(oe_b), .busy_b_out(busy_b), .cal_active_in(cal),
        .conv_done_in(done), .conv_result_in(res), .conv_start_out(start),
        .conv_channel_out(chan), .special_reg_out(sreg));

    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (e !== g) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // Bounded wait for a start pulse
    task automatic wait_start(output logic s);
        s = 0;
        repeat (20) begin
            @(negedge clk);
            if (start === 1'b1) s = 1;
            if (s) break;
        end
    endtask
    task automatic finish_conv(input logic [11:0] r);
        repeat (($random(seed) & 7) + 2) @(posedge clk);
        #1; done = 1; res = r;
        @(posedge clk); #1; done = 0;
        repeat (2) @(negedge clk);
        chk("busy_b done", 1, busy_b);
    endtask
    task automatic convert(input logic [1:0] ch, input logic [11:0] r);
        h.wr(ch, 0, 8'h00, 1);
        wait_start(got);
        chk("start", 1, got);
        chk("channel", ch, chan);
        @(negedge clk); chk("busy_b conv", 0, busy_b);
        h.rd(1, q, ob); chk("status busy", 1, q[7]);
        finish_conv(r);
        h.rd(0, q, ob); chk("low byte", r[7:0], q);
        chk("oe_b read", 0, ob);
        h.rd(1, q, ob); chk("high byte", {4'h0, r[11:8]}, q);
        // Release needs three edges to reach the registered enable
        repeat (4) @(negedge clk);
        chk("oe_b idle", 1, oe_b);
    endtask

    initial begin
        #80000; errors++;
        results();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1; rst_b = 1;
        repeat (4) @(posedge clk);
        convert(2'h3, 12'hFFF);
        convert(2'h0, 12'h000);
        for (int i = 0; i < 4; i++) convert(i[1:0], 12'($random(seed)));
        h.wr(2'h2, 0, 8'h00, 0);
        wait_start(got);
        chk("start no cs", 0, got);
        d = 8'($random(seed));
        h.wr(2'h1, 1, d, 1);
        wait_start(got);
        chk("start special", 0, got);
        chk("special reg", d, sreg);
        @(posedge clk);
        #1;
        cal = 1;
        repeat (2) @(negedge clk);
        chk("busy_b cal", 0, busy_b);
        h.wr(2'h1, 0, 8'h00, 1);
        wait_start(got);
        chk("start cal", 0, got);
        h.rd(1, q, ob);
        chk("status cal", 1, q[7]);
        @(posedge clk);
        #1;
        cal = 0;
        // Conversion appended after calibration must refuse a fresh start
        h.wr(2'h2, 0, 8'h00, 1);
        wait_start(got);
        chk("start converting", 0, got);
        finish_conv(12'h5A3);
        convert(2'h1, 12'($random(seed)));
        results();
    end
endmodule
